/* hw/led_fault_pkg.sv */
// Purpose: shared constants and carriers for the led driver fault monitor
// Assumes: 10 MHz system clock, classic wishbone register access
// Notes:   status registers sit at printed index, byte address is index * 4
package led_fault_pkg;

  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          NUM_STRINGS     = 4;

  // register indices and byte addressing
  localparam logic [5:0]  REG_IDX_STR12   = 6'h05;
  localparam logic [5:0]  REG_IDX_STR34   = 6'h06;
  localparam logic [5:0]  REG_IDX_FAULTS  = 6'h07;
  localparam int          WB_ADR_W        = 8;
  localparam int          WB_DAT_W        = 32;
  localparam int          WB_SEL_W        = 4;

  // string register field positions (upper pair uses the low bits)
  localparam int          STR_UNUSED_HI_B = 7;
  localparam int          STR_UNUSED_LO_B = 6;
  localparam int          STR_HI_OV_B     = 5;
  localparam int          STR_HI_OPEN_B   = 4;
  localparam int          STR_HI_UNUSED_B = 3;
  localparam int          STR_LO_OV_B     = 2;
  localparam int          STR_LO_OPEN_B   = 1;
  localparam int          STR_LO_UNUSED_B = 0;
  localparam logic [1:0]  UNUSED_RESET    = 2'h0;

  // timing figures in their own units and derived cycle counts
  localparam int          TD_MAX_NS        = 1000;
  localparam int          TD_MAX_CYCLES    = TD_MAX_NS / CLK_PERIOD_NS;
  localparam int          POR_TIME_US      = 100;
  localparam int          POR_CYCLES       =
    (POR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          FLAG_EXT_TIME_US = 8000;
  localparam int          FLAG_EXT_CYCLES  =
    (FLAG_EXT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // over-current protection: blanking and window in switching clock periods, shutdown after a count of events
  localparam logic [2:0]  OC_BLANK_TICKS   = 3'h4;
  localparam logic [2:0]  OVERCURRENT_SHUTDOWN_EVENTS   = 3'h4;
  localparam logic [6:0]  OC_WINDOW_LAST   = 7'h7f;

  // fault register 07h layout
  typedef struct packed {
    logic oc_shutdown;
    logic overcurrent;
    logic overtemp;
    logic temp_warning;
  } fault_bits_s;

  // every asynchronous pin that enters the block
  typedef struct packed {
    logic                   enable;
    logic                   overtemp;
    logic                   temp_warning;
    logic                   overcurrent;
    logic                   low_side_ok;
    logic                   high_side_ok;
    logic                   soft_start_low;
    logic                   switch_clk;
    logic [NUM_STRINGS-1:0] dimming_pwm;
    logic [NUM_STRINGS-1:0] string_overvoltage;
    logic [NUM_STRINGS-1:0] string_open;
  } pin_in_s;

  typedef enum logic [2:0] {
    ST_SLEEP  = 3'b000,
    ST_LOW_ON = 3'b001,
    ST_HIGH_ON = 3'b010,
    ST_POR    = 3'b011,
    ST_RUN    = 3'b100,
    ST_HICCUP = 3'b101
  } power_state_e;

endpackage

/* hw/led_fault_monitor.sv */
// Purpose: fault latching, fault flag, power-up order and over-current
//          hiccup control for a four string led boost driver
// Assumes: all pins arrive asynchronous and pass a two stage synchroniser
// Notes:   status reached over classic wishbone, one answer per request
//
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/1ps

module led_fault_monitor
  import led_fault_pkg::*;
#(
  parameter int FLAG_EXTEND_CYCLES = FLAG_EXT_CYCLES
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [WB_ADR_W-1:0]    wb_adr_i,
  input  wire logic [WB_DAT_W-1:0]    wb_dat_i,
  input  wire logic [WB_SEL_W-1:0]    wb_sel_i,
  output logic      [WB_DAT_W-1:0]    wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   enable_i,
  input  wire logic                   overtemp_i,
  input  wire logic                   temp_warning_i,
  input  wire logic                   overcurrent_i,
  input  wire logic                   low_side_supply_ok_i,
  input  wire logic                   high_side_supply_ok_i,
  input  wire logic                   soft_start_low_i,
  input  wire logic                   switch_clk_i,
  input  wire logic [NUM_STRINGS-1:0] dimming_pwm_i,
  input  wire logic [NUM_STRINGS-1:0] string_overvoltage_i,
  input  wire logic [NUM_STRINGS-1:0] string_open_i,
  output logic                        fault_flag_n_o,
  output logic                        low_side_supply_en_o,
  output logic                        high_side_supply_en_o,
  output logic                        por_active_o,
  output logic                        sleep_o,
  output logic                        converter_run_o,
  output logic                        switch_gate_drive_o,
  output logic                        soft_start_cap_discharge_o
);

  localparam int EXT_W = $clog2(FLAG_EXTEND_CYCLES + 1);
  localparam int POR_W = $clog2(POR_CYCLES + 1);

  // refuse a zero extension at elaboration, the timer would never load
  if (FLAG_EXTEND_CYCLES < 1) begin : g_bad_extend
    $error("FLAG_EXTEND_CYCLES must be at least one");
  end

  // synchroniser: stage one feeds stage two only
  pin_in_s pin_raw;
  pin_in_s pin_meta;
  pin_in_s pin;
  logic    sw_prev;
  logic    oc_prev;

  assign pin_raw = '{enable:             enable_i,
                     overtemp:           overtemp_i,
                     temp_warning:       temp_warning_i,
                     overcurrent:        overcurrent_i,
                     low_side_ok:        low_side_supply_ok_i,
                     high_side_ok:       high_side_supply_ok_i,
                     soft_start_low:     soft_start_low_i,
                     switch_clk:         switch_clk_i,
                     dimming_pwm:        dimming_pwm_i,
                     string_overvoltage: string_overvoltage_i,
                     string_open:        string_open_i};

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pin_meta <= '0;
      pin      <= '0;
      sw_prev  <= 1'b0;
      oc_prev  <= 1'b0;
    end else begin
      pin_meta <= pin_raw;
      pin      <= pin_meta;
      sw_prev  <= pin.switch_clk;
      oc_prev  <= pin.overcurrent;
    end
  end

  logic sw_tick;
  logic oc_event;
  assign sw_tick  = pin.switch_clk & ~sw_prev;
  assign oc_event = pin.overcurrent & ~oc_prev;

  // register bus
  logic                req;
  logic                ack;
  logic [WB_DAT_W-1:0] rdata;
  logic                next_ack;
  logic [WB_DAT_W-1:0] next_rdata;
  logic [WB_DAT_W-1:0] rd_mux;
  logic                rd_done;
  logic                wr_done;
  logic                rd_str;
  logic                rd_flt;

  // status state
  fault_bits_s            flt;
  fault_bits_s            next_flt;
  logic [1:0]             rd_pend;
  logic [1:0]             next_rd_pend;
  logic [NUM_STRINGS-1:0] unused_mask;
  logic [NUM_STRINGS-1:0] next_unused_mask;
  logic [NUM_STRINGS-1:0] s_open;
  logic [NUM_STRINGS-1:0] next_s_open;
  logic [NUM_STRINGS-1:0] s_ov;
  logic [NUM_STRINGS-1:0] next_s_ov;
  logic                   str_flag;
  logic                   next_str_flag;
  logic [EXT_W-1:0]       ext_cnt;
  logic [EXT_W-1:0]       next_ext_cnt;
  logic                   fault_active;

  // power and protection state
  power_state_e state;
  power_state_e next_state;
  logic [POR_W-1:0] por_cnt;
  logic [POR_W-1:0] next_por_cnt;
  logic [2:0]       blank_cnt;
  logic [2:0]       next_blank_cnt;
  logic [2:0]       evt_cnt;
  logic [2:0]       next_evt_cnt;
  logic [6:0]       win_cnt;
  logic [6:0]       next_win_cnt;
  logic             hiccup_start;
  logic             string_demand;

  // register read view
  logic [7:0] str12_view;
  logic [7:0] str34_view;
  assign str12_view = {unused_mask[0], unused_mask[1],
                       s_ov[0], s_open[0], unused_mask[0],
                       s_ov[1], s_open[1], unused_mask[1]};
  assign str34_view = {unused_mask[2], unused_mask[3],
                       s_ov[2], s_open[2], unused_mask[2],
                       s_ov[3], s_open[3], unused_mask[3]};

  assign req     = wb_cyc_i & wb_stb_i;
  assign rd_done = req & ack & ~wb_we_i;
  assign wr_done = req & ack & wb_we_i & wb_sel_i[0];
  assign rd_str  = rd_done & ((wb_adr_i[7:2] == REG_IDX_STR12) |
                              (wb_adr_i[7:2] == REG_IDX_STR34));
  assign rd_flt  = rd_done & (wb_adr_i[7:2] == REG_IDX_FAULTS);

  always_comb begin
    case (wb_adr_i[7:2])
      REG_IDX_STR12:  rd_mux = {24'h000000, str12_view};
      REG_IDX_STR34:  rd_mux = {24'h000000, str34_view};
      REG_IDX_FAULTS: rd_mux = {28'h0000000, flt};
      default:        rd_mux = '0;
    endcase
    next_ack   = req & ~ack;
    next_rdata = (req & ~ack & ~wb_we_i) ? rd_mux : rdata;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ack   <= 1'b0;
      rdata <= '0;
    end else begin
      ack   <= next_ack;
      rdata <= next_rdata;
    end
  end

  // status bits and fault flag
  always_comb begin
    fault_bits_s clr;
    fault_bits_s set;
    logic [NUM_STRINGS-1:0] open_set;
    logic [NUM_STRINGS-1:0] ov_set;
    clr      = '0;
    set      = '0;
    open_set = '0;
    ov_set   = '0;
    next_rd_pend     = rd_pend;
    next_unused_mask = unused_mask;

    // software marks unused strings so their faults are masked
    if (wr_done && wb_adr_i[7:2] == REG_IDX_STR12) begin
      next_unused_mask[0] = wb_dat_i[STR_UNUSED_HI_B];
      next_unused_mask[1] = wb_dat_i[STR_UNUSED_LO_B];
    end
    if (wr_done && wb_adr_i[7:2] == REG_IDX_STR34) begin
      next_unused_mask[2] = wb_dat_i[STR_UNUSED_HI_B];
      next_unused_mask[3] = wb_dat_i[STR_UNUSED_LO_B];
    end

    set.overtemp     = pin.overtemp;
    set.temp_warning = pin.temp_warning;
    set.overcurrent  = pin.overcurrent & (state != ST_SLEEP);
    set.oc_shutdown  = hiccup_start;

    // only bits the host actually saw are cleared, so a set that
    // lands between the data capture and completion survives
    if (rd_flt) begin
      clr.overcurrent = rdata[2];
      clr.oc_shutdown = rdata[3];
      next_rd_pend    = next_rd_pend | rdata[1:0];
    end
    if (rd_pend[1] && !pin.overtemp) begin
      clr.overtemp    = 1'b1;
      next_rd_pend[1] = 1'b0;
    end
    if (rd_pend[0] && !pin.temp_warning) begin
      clr.temp_warning = 1'b1;
      next_rd_pend[0]  = 1'b0;
    end
    if (state == ST_SLEEP) begin
      clr.overcurrent = 1'b1;
      clr.oc_shutdown = 1'b1;
    end
    next_flt = (flt & ~clr) | set;

    if (state != ST_SLEEP) begin
      open_set = pin.string_open & ~unused_mask;
      ov_set   = pin.string_overvoltage & ~unused_mask;
    end
    // string status only leaves through an enable cycle
    next_s_open = (state == ST_SLEEP) ? '0 : (s_open | open_set);
    next_s_ov   = (state == ST_SLEEP) ? '0 : (s_ov | ov_set);
    next_str_flag = (str_flag & ~(rd_str | rd_flt)) |
                    (|(open_set & ~s_open)) |
                    (|(ov_set & ~s_ov));

    if (fault_active)
      next_ext_cnt = EXT_W'(FLAG_EXTEND_CYCLES);
    else if (ext_cnt != '0)
      next_ext_cnt = ext_cnt - 1'b1;
    else
      next_ext_cnt = ext_cnt;
  end

  assign fault_active = (|flt) | str_flag |
                        pin.overtemp | pin.temp_warning;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      flt         <= '0;
      rd_pend     <= 2'h0;
      unused_mask <= {UNUSED_RESET, UNUSED_RESET};
      s_open      <= '0;
      s_ov        <= '0;
      str_flag    <= 1'b0;
      ext_cnt     <= '0;
    end else begin
      flt         <= next_flt;
      rd_pend     <= next_rd_pend;
      unused_mask <= next_unused_mask;
      s_open      <= next_s_open;
      s_ov        <= next_s_ov;
      str_flag    <= next_str_flag;
      ext_cnt     <= next_ext_cnt;
    end
  end

  // power sequencing and over-current protection
  assign string_demand = |(pin.dimming_pwm & ~unused_mask);
  assign hiccup_start  = (state == ST_RUN) && oc_event &&
                         (evt_cnt == OVERCURRENT_SHUTDOWN_EVENTS - 3'h1);

  always_comb begin
    next_state     = state;
    next_por_cnt   = por_cnt;
    next_blank_cnt = blank_cnt;
    next_evt_cnt   = evt_cnt;
    next_win_cnt   = win_cnt;
    case (state)
      ST_SLEEP: begin
        if (pin.enable)
          next_state = ST_LOW_ON;
      end
      ST_LOW_ON: begin
        if (pin.low_side_ok)
          next_state = ST_HIGH_ON;
      end
      ST_HIGH_ON: begin
        next_por_cnt = '0;
        if (pin.high_side_ok)
          next_state = ST_POR;
      end
      ST_POR: begin
        next_por_cnt = por_cnt + 1'b1;
        if (por_cnt == POR_W'(POR_CYCLES - 1))
          next_state = ST_RUN;
      end
      ST_RUN: begin
        if (sw_tick)
          next_win_cnt = win_cnt + 1'b1;
        if (sw_tick && win_cnt == OC_WINDOW_LAST)
          next_evt_cnt = '0;
        else if (oc_event)
          next_evt_cnt = evt_cnt + 1'b1;
        if (oc_event)
          next_blank_cnt = OC_BLANK_TICKS;
        else if (sw_tick && blank_cnt != '0)
          next_blank_cnt = blank_cnt - 1'b1;
        if (hiccup_start) begin
          next_state     = ST_HICCUP;
          next_evt_cnt   = '0;
          next_blank_cnt = '0;
        end
      end
      ST_HICCUP: begin
        // restarting blind keeps retrying while the fault stays
        if (pin.soft_start_low)
          next_state = ST_RUN;
      end
      default: next_state = ST_SLEEP;
    endcase
    if (!pin.enable) begin
      next_state     = ST_SLEEP;
      next_evt_cnt   = '0;
      next_blank_cnt = '0;
      next_win_cnt   = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state     <= ST_SLEEP;
      por_cnt   <= '0;
      blank_cnt <= '0;
      evt_cnt   <= '0;
      win_cnt   <= '0;
    end else begin
      state     <= next_state;
      por_cnt   <= next_por_cnt;
      blank_cnt <= next_blank_cnt;
      evt_cnt   <= next_evt_cnt;
      win_cnt   <= next_win_cnt;
    end
  end

  // registered outputs
  logic run_ok;
  assign run_ok = (state == ST_RUN) && !pin.overtemp && string_demand;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      fault_flag_n_o             <= 1'b1;
      low_side_supply_en_o       <= 1'b0;
      high_side_supply_en_o      <= 1'b0;
      por_active_o               <= 1'b0;
      sleep_o                    <= 1'b1;
      converter_run_o            <= 1'b0;
      switch_gate_drive_o        <= 1'b0;
      soft_start_cap_discharge_o <= 1'b0;
      wb_ack_o                   <= 1'b0;
      wb_dat_o                   <= '0;
    end else begin
      // flag latency is sync, latch and this stage, well inside the bound
      fault_flag_n_o <= ~(fault_active | (ext_cnt != '0));
      low_side_supply_en_o  <= (state != ST_SLEEP);
      high_side_supply_en_o <= (state != ST_SLEEP) && (state != ST_LOW_ON);
      por_active_o          <= (state == ST_POR);
      sleep_o               <= (state == ST_SLEEP);
      converter_run_o       <= run_ok;
      switch_gate_drive_o   <= run_ok && (blank_cnt == '0) &&
                               !oc_event;
      soft_start_cap_discharge_o <= (state == ST_HICCUP);
      wb_ack_o              <= next_ack;
      wb_dat_o              <= next_rdata;
    end
  end

endmodule

/* dv/led_fault_chk_monitor.sv */
// Purpose: concurrent checks on the fault monitor ports
// Assumes: one clock domain, synchronous active high reset
// Notes:   counters stand in for spans longer than a repetition
`timescale 1ns/1ps
module led_fault_chk
  import led_fault_pkg::*;
#(
  parameter int FLAG_EXTEND_CYCLES = 20
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic overtemp_i,
  input wire logic temp_warning_i,
  input wire logic switch_clk_i,
  input wire logic fault_flag_n_o,
  input wire logic low_side_supply_en_o,
  input wire logic high_side_supply_en_o,
  input wire logic por_active_o,
  input wire logic sleep_o,
  input wire logic converter_run_o,
  input wire logic switch_gate_drive_o,
  input wire logic soft_start_cap_discharge_o
);
  logic [15:0] por_cnt;
  logic [15:0] quiet_cnt;
  logic [3:0]  sw_cnt;
  logic        sw_q;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // power-on length, temperature quiet time, and switch edges seen while the gate is blanked inside run
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sw_q      <= 1'b0;
      por_cnt   <= 16'h0;
      quiet_cnt <= 16'h0;
      sw_cnt    <= 4'h0;
    end else begin
      sw_q    <= switch_clk_i;
      por_cnt <= por_active_o ? por_cnt + 16'h1 : 16'h0;
      if (overtemp_i || temp_warning_i)
        quiet_cnt <= 16'h0;
      else if (quiet_cnt != 16'hffff)
        quiet_cnt <= quiet_cnt + 16'h1;
      if (!converter_run_o || switch_gate_drive_o)
        sw_cnt <= 4'h0;
      else if (switch_clk_i && !sw_q && sw_cnt != 4'hf)
        sw_cnt <= sw_cnt + 4'h1;
    end
  end
  AST_OT_FLAG: assert property (
    overtemp_i [*8] |-> !fault_flag_n_o) else $error("flag high in overtemp");
  AST_WARN_FLAG: assert property (
    temp_warning_i [*8] |-> !fault_flag_n_o) else $error("flag high in warning");
  AST_SLEEP_IDLE: assert property (
    sleep_o |-> !high_side_supply_en_o && !converter_run_o
    && !switch_gate_drive_o) else $error("activity while asleep");
  AST_LOW_FIRST: assert property (
    $rose(high_side_supply_en_o) |-> low_side_supply_en_o)
    else $error("high side before low side");
  AST_POR_LEN: assert property (
    $fell(por_active_o) && !sleep_o |-> por_cnt >= 16'h03de
    && por_cnt <= 16'h03f2) else $error("power-on wait length wrong");
  AST_GATE_BLANK: assert property (
    $rose(switch_gate_drive_o) && $past(converter_run_o, 2)
    |-> sw_cnt >= 4'h3 && sw_cnt <= 4'h6) else $error("blank span wrong");
  AST_DISCH_STOP: assert property (
    soft_start_cap_discharge_o |-> !converter_run_o && !switch_gate_drive_o)
    else $error("running during discharge");
  AST_ACK_PULSE: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle answer");
  AST_FLAG_HOLD: assert property (
    $rose(fault_flag_n_o) |-> quiet_cnt >= FLAG_EXTEND_CYCLES)
    else $error("flag released before extension");
endmodule

bind led_fault_monitor led_fault_chk #(
  .FLAG_EXTEND_CYCLES(FLAG_EXTEND_CYCLES)
) u_chk (.sys_clk_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .overtemp_i,
  .temp_warning_i, .switch_clk_i, .fault_flag_n_o, .low_side_supply_en_o,
  .high_side_supply_en_o, .por_active_o, .sleep_o, .converter_run_o,
  .switch_gate_drive_o, .soft_start_cap_discharge_o);

/* dv/led_fault_host.sv */
// Purpose: management host issuing classic wishbone cycles
// Assumes: slave answers with ack, no wait bound of its own
// Notes:   idle address and data are scrambled so stale values never match
`timescale 1ns/1ps
module led_fault_host
  import led_fault_pkg::*;
(
  input  wire logic                sys_clk_i,
  input  wire logic                ack_i,
  output logic                     cyc_o,
  output logic                     stb_o,
  output logic                     we_o,
  output logic     [WB_ADR_W-1:0]  adr_o,
  output logic     [WB_DAT_W-1:0]  dat_o,
  output logic     [WB_SEL_W-1:0]  sel_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    dat_o = 32'h0;
    sel_o = 4'h0;
  end
  // one classic cycle per call, strobe held until ack, then address and data scrambled
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge sys_clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    dat_o <= d;
    sel_o <= 4'hf;
    do @(posedge sys_clk_i); while (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
endmodule

/* dv/led_fault_monitor_tb_top.sv */
// Purpose: self-checking bench for the fault monitor
// Assumes: shortened flag extension, switch clock at a tenth of sys clock
// Notes:   read data is checked by a watcher fed from a queue
`timescale 1ns/1ps
module led_fault_monitor_tb_top;
  import led_fault_pkg::*;
  localparam int EXT = 20;
  logic        clk, rst, cyc, stb, we, ack, flag_n, lo_en, hi_en;
  logic        por, slp, run, gate, disch;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, d;
  logic [3:0]  sel;
  logic [2:0]  sw_div = 3'h0;
  logic        sw_clk = 1'b0;
  pin_in_s     p;
  logic [31:0] exp_q[$];
  int          mismatches, n_compared, seed, i, k;

  led_fault_host u_host (.sys_clk_i(clk), .ack_i(ack), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .dat_o(wdat), .sel_o(sel));
  led_fault_monitor #(.FLAG_EXTEND_CYCLES(EXT)) dut (.sys_clk_i(clk),
    .reset_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .enable_i(p.enable), .overtemp_i(p.overtemp),
    .temp_warning_i(p.temp_warning), .overcurrent_i(p.overcurrent),
    .low_side_supply_ok_i(p.low_side_ok),
    .high_side_supply_ok_i(p.high_side_ok),
    .soft_start_low_i(p.soft_start_low), .switch_clk_i(sw_clk),
    .dimming_pwm_i(p.dimming_pwm), .string_overvoltage_i(p.string_overvoltage),
    .string_open_i(p.string_open), .fault_flag_n_o(flag_n),
    .low_side_supply_en_o(lo_en), .high_side_supply_en_o(hi_en),
    .por_active_o(por), .sleep_o(slp), .converter_run_o(run),
    .switch_gate_drive_o(gate), .soft_start_cap_discharge_o(disch));

  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end
  // free running converter clock, unrelated to bus traffic
  always @(posedge clk) begin
    sw_div <= (sw_div == 3'h4) ? 3'h0 : sw_div + 3'h1;
    if (sw_div == 3'h4) sw_clk <= ~sw_clk;
  end

  task automatic check(input string n, input logic [31:0] seen,
                       input logic [31:0] e);
    n_compared++;
    if (seen !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b0, a, 32'h0);
  endtask
  task automatic wait_lvl(input string n, ref logic s, input logic v);
    for (int j = 0; j < 3000 && s !== v; j++) @(posedge clk);
    check(n, {31'h0, s}, {31'h0, v});
  endtask
  task automatic oc_pulse();
    @(posedge clk) p.overcurrent <= 1'b1;
    repeat (3) @(posedge clk);
    p.overcurrent <= 1'b0;
    repeat (60) @(posedge clk);
  endtask

  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
      check("read data", rdat, exp_q.pop_front());
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    p = '0;
    p.dimming_pwm = 4'hf;
    seed = 89;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("flag idle", {31'h0, flag_n}, 32'h1);
    check("asleep", {31'h0, slp}, 32'h1);
    rd(8'h00, 32'h0);
    p.enable <= 1'b1;
    wait_lvl("low side on", lo_en, 1'b1);
    check("high side waits", {31'h0, hi_en}, 32'h0);
    p.low_side_ok <= 1'b1;
    wait_lvl("high side on", hi_en, 1'b1);
    p.high_side_ok <= 1'b1;
    wait_lvl("por", por, 1'b1);
    wait_lvl("run", run, 1'b1);
    p.dimming_pwm <= 4'h0;
    wait_lvl("idle no pwm", run, 1'b0);
    p.dimming_pwm <= 4'h1 << ($unsigned($random(seed)) % 4);
    wait_lvl("run one pwm", run, 1'b1);
    for (k = 0; k < 2; k++) begin
      if (k == 1) p.overtemp <= 1'b1;
      else p.temp_warning <= 1'b1;
      repeat (10) @(posedge clk);
      check("flag on temp", {31'h0, flag_n}, 32'h0);
      if (k == 1) check("stop hot", {31'h0, run}, 32'h0);
      rd(8'h1c, 32'h1 << k);
      rd(8'h1c, 32'h1 << k);
      p.overtemp <= 1'b0;
      p.temp_warning <= 1'b0;
      repeat (10) @(posedge clk);
      rd(8'h1c, 32'h0);
      wait_lvl("flag back", flag_n, 1'b1);
      wait_lvl("resume", run, 1'b1);
    end
    @(posedge clk) p.overcurrent <= 1'b1;
    @(posedge clk) p.overcurrent <= 1'b0;
    wait_lvl("gate off", gate, 1'b0);
    wait_lvl("gate back", gate, 1'b1);
    rd(8'h1c, 32'h4);
    rd(8'h1c, 32'h0);
    wait_lvl("flag after oc", flag_n, 1'b1);
    for (k = 0; k < 2; k++) begin
      for (i = 0; i < 12 && disch !== 1'b1; i++) oc_pulse();
      check("hiccup", {31'h0, disch}, 32'h1);
      rd(8'h1c, 32'hc);
      p.soft_start_low <= 1'b1;
      wait_lvl("restart", run, 1'b1);
      p.soft_start_low <= 1'b0;
      rd(8'h1c, 32'h0);
    end
    p.string_open[0] <= 1'b1;
    repeat (10) @(posedge clk);
    check("flag on open", {31'h0, flag_n}, 32'h0);
    rd(8'h14, 32'h10);
    p.string_open[0] <= 1'b0;
    rd(8'h14, 32'h10);
    rd(8'h1c, 32'h0);
    wait_lvl("flag released", flag_n, 1'b1);
    d = $random(seed);
    d[7:6] = 2'b10;
    u_host.xfer(1'b1, 8'h18, d);
    p.string_overvoltage[3:2] <= 2'b11;
    repeat (10) @(posedge clk);
    rd(8'h18, 32'h8c);
    p.enable <= 1'b0;
    p.string_overvoltage <= '0;
    wait_lvl("sleep", slp, 1'b1);
    p.enable <= 1'b1;
    wait_lvl("wake", lo_en, 1'b1);
    rd(8'h14, 32'h0);
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule
